// >>> rtl/adc_touch_pkg.sv
// Constants, types and register layout of the converter and touch-panel control.
// Operation
// - Axis select 00, no auto: plain conversion on chosen channel into X result.
// - Axis select 01: convert X, store X result, pulse conversion done.
// - Axis select 10: convert Y, store Y result, pulse conversion done.
// - X conversion: X-plus to supply, X-minus grounded, Y-plus to input 5.
// - Y conversion: X-plus to input 7, Y-plus to supply, Y-minus grounded.
// - Auto sequence: X then Y into both results, one done pulse after both.
// - Axis select 11: wait for stylus down, then pulse touch interrupt.
// - Stylus wait: X-plus pull-up on, Y-minus grounded; channel stays as selected.
// - Standby halts conversions; both results keep their last values.
// - Control bit 15 reads end of conversion: cleared at start, set as each result is stored.
// - Conversion clock is core clock over N+1, running only when enabled.
// - Bits 5 to 3 pick analog input 0 to 7; 7 is the X-plus pad.
// - Start-by-read set: a result read while idle starts a new conversion.
// - Writing start bit begins a conversion, self-clears; ignored under start-by-read.
// - Touch bit 7 drives the Y-minus ground switch output.
// - Touch bit 6 drives the active-low Y-plus supply switch; resets to 1.
// - Touch bit 5 drives the X-minus ground switch output.
// - Touch bit 4 drives the active-low X-plus supply switch; resets to 1.
// - Touch bit 3 is the active-low X-plus pull-up switch; resets to 1.
// - Touch bit 2 is auto sequence; bits 1 to 0 are axis select.
// - Each conversion lasts five conversion clock cycles.
// - Each result is ten bits, at bits 9 to 0 of its register.
// - Delay value sets settling before axis conversion and touch interrupt spacing.
package adc_touch_pkg;

    localparam logic [31:0] OFF_CONTROL = 32'h5800_0000;
    localparam logic [31:0] OFF_TOUCH = 32'h5800_0004;
    localparam logic [31:0] OFF_DELAY = 32'h5800_0008;
    localparam logic [31:0] OFF_RESULT0 = 32'h5800_000C;
    localparam logic [31:0] OFF_RESULT1 = 32'h5800_0010;

    // Control register fields.
    localparam int CTL_END_FLAG = 15;
    localparam int CTL_DIV_EN = 14;
    localparam int CTL_DIV_HI = 13;
    localparam int CTL_DIV_LO = 6;
    localparam int CTL_CHAN_HI = 5;
    localparam int CTL_CHAN_LO = 3;
    localparam int CTL_STANDBY = 2;
    localparam int CTL_READ_START = 1;
    localparam int CTL_START = 0;

    // Touch control fields.
    localparam int TS_AUTO = 2;
    localparam int TS_AXIS_HI = 1;
    localparam int TS_AXIS_LO = 0;

    // Result register fields.
    localparam int RES_UPDOWN = 15;
    localparam int RES_AUTO = 14;
    localparam int RES_AXIS_HI = 13;
    localparam int RES_AXIS_LO = 12;
    localparam int RESULT_W = 10;

    localparam logic [15:0] CONTROL_RESET = 16'h3FC4;
    localparam logic [7:0] TOUCH_RESET = 8'h58;
    localparam logic [15:0] DELAY_RESET = 16'h00FF;

    localparam logic [1:0] AXIS_NONE = 2'h0;
    localparam logic [1:0] AXIS_X = 2'h1;
    localparam logic [1:0] AXIS_Y = 2'h2;
    localparam logic [1:0] AXIS_WAIT = 2'h3;

    localparam logic [2:0] CHAN_Y_PLUS = 3'h5;
    localparam logic [2:0] CHAN_X_PLUS = 3'h7;

    // Conversion length in conversion clock ticks.
    localparam logic [2:0] CONV_TICKS = 3'h5;

    // Pad switch word: {y_minus, y_plus_n, x_minus, x_plus_n, pullup_n}.
    localparam logic [4:0] PADS_X = 5'h0D;
    localparam logic [4:0] PADS_Y = 5'h13;
    localparam logic [4:0] PADS_WAIT = 5'h1A;

    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT} seq_state_t;
    typedef enum logic [1:0] {PH_NORMAL, PH_X, PH_Y} phase_t;

endpackage

// >>> rtl/adc_touch_screen_control.sv
// Register slave, prescaler, conversion sequencer and pad switch control.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module adc_touch_screen_control
    import adc_touch_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [RESULT_W-1:0] adc_data_i,
    input wire logic stylus_down_i,
    output logic adc_start_o,
    output logic adc_clk_tick_o,
    output logic [2:0] adc_channel_o,
    output logic adc_standby_o,
    output logic y_minus_ground_out_o,
    output logic y_plus_drive_out_n_o,
    output logic x_minus_ground_out_o,
    output logic x_plus_drive_out_n_o,
    output logic x_pullup_out_n_o,
    output logic conversion_done_irq_o,
    output logic stylus_touch_irq_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic divider_enable;
        logic [7:0] divider_value;
        logic [2:0] channel_select;
        logic standby_select;
        logic read_start;
        logic start_bit;
        logic conversion_end_flag;
        logic [7:0] touch_pad_control;
        logic [15:0] settle_delay;
        logic [RESULT_W-1:0] x_result_field;
        logic [RESULT_W-1:0] y_result_field;
        seq_state_t state;
        phase_t phase;
        logic auto_run;
        logic [15:0] wait_cnt;
        logic [2:0] tick_cnt;
        logic [7:0] div_cnt;
        logic tick;
        logic conv_start;
        logic done_irq;
        logic touch_irq;
        logic [15:0] touch_cnt;
        logic [4:0] pads;
        logic [2:0] channel_out;
    } state_t;

    localparam state_t RESET_STATE = '{
        ack: 1'b0,
        rdata: 32'h0000_0000,
        divider_enable: CONTROL_RESET[CTL_DIV_EN],
        divider_value: CONTROL_RESET[CTL_DIV_HI:CTL_DIV_LO],
        channel_select: CONTROL_RESET[CTL_CHAN_HI:CTL_CHAN_LO],
        standby_select: CONTROL_RESET[CTL_STANDBY],
        read_start: CONTROL_RESET[CTL_READ_START],
        start_bit: CONTROL_RESET[CTL_START],
        conversion_end_flag: CONTROL_RESET[CTL_END_FLAG],
        touch_pad_control: TOUCH_RESET,
        settle_delay: DELAY_RESET,
        x_result_field: '0,
        y_result_field: '0,
        state: ST_IDLE,
        phase: PH_NORMAL,
        auto_run: 1'b0,
        wait_cnt: 16'h0000,
        tick_cnt: 3'h0,
        div_cnt: 8'h00,
        tick: 1'b0,
        conv_start: 1'b0,
        done_irq: 1'b0,
        touch_irq: 1'b0,
        touch_cnt: 16'h0000,
        pads: TOUCH_RESET[7:3],
        channel_out: CONTROL_RESET[CTL_CHAN_HI:CTL_CHAN_LO]
    };

    state_t s;
    state_t next_s;

    // Builds a result register word; the axis fields echo the live mode.
    function automatic logic [31:0] result_word(
        input logic [RESULT_W-1:0] value,
        input logic [7:0] tsc,
        input logic stylus
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[RES_UPDOWN] = ~stylus;
        w[RES_AUTO] = tsc[TS_AUTO];
        w[RES_AXIS_HI:RES_AXIS_LO] = tsc[TS_AXIS_HI:TS_AXIS_LO];
        w[RESULT_W-1:0] = value;
        return w;
    endfunction

    // Decoded request, mode and delay terms of the current cycle.
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic read_start_evt;
    logic start_req;
    logic [1:0] axis;
    logic auto_seq;
    logic [15:0] delay_load;

    // Next-state logic. The sequencer runs before the bus writes so that a
    // start bit written in the cycle it self-clears is kept, not lost.
    always_comb begin
        next_s = s;
        // Every pulse output defaults low and lasts one enabled cycle.
        next_s.ack = 1'b0;
        next_s.conv_start = 1'b0;
        next_s.done_irq = 1'b0;
        next_s.touch_irq = 1'b0;
        next_s.tick = 1'b0;

        bus_req = wb_cyc_i & wb_stb_i & ~s.ack;
        bus_wr = bus_req & wb_we_i;
        bus_rd = bus_req & ~wb_we_i;
        axis = s.touch_pad_control[TS_AXIS_HI:TS_AXIS_LO];
        auto_seq = s.touch_pad_control[TS_AUTO];
        // A zero delay would never count down cleanly, so it acts as one.
        delay_load = (s.settle_delay == 16'h0000) ? 16'h0001 : s.settle_delay;

        // Only a result read restarts; control or touch reads never do.
        read_start_evt = bus_rd & s.read_start
            & (wb_adr_i == OFF_RESULT0 | wb_adr_i == OFF_RESULT1);
        start_req = s.read_start ? read_start_evt : s.start_bit;

        // Prescaler: one tick every N+1 core cycles, cleared to zero while disabled.
        if (s.divider_enable) begin
            if (s.div_cnt == s.divider_value) begin
                next_s.div_cnt = 8'h00;
                next_s.tick = 1'b1;
            end else begin
                next_s.div_cnt = s.div_cnt + 8'h01;
            end
        end else begin
            next_s.div_cnt = 8'h00;
        end

        // Conversion sequencer.
        unique case (s.state)
            ST_IDLE: begin
                if (start_req && !s.standby_select) begin
                    next_s.start_bit = 1'b0;
                    next_s.conversion_end_flag = 1'b0;
                    next_s.auto_run = auto_seq && axis == AXIS_NONE;
                    if ((auto_seq && axis == AXIS_NONE) || axis == AXIS_X) begin
                        next_s.phase = PH_X;
                        next_s.state = ST_SETTLE;
                        next_s.wait_cnt = delay_load;
                    end else if (axis == AXIS_Y) begin
                        next_s.phase = PH_Y;
                        next_s.state = ST_SETTLE;
                        next_s.wait_cnt = delay_load;
                    end else begin
                        next_s.phase = PH_NORMAL;
                        next_s.state = ST_CONVERT;
                        next_s.conv_start = 1'b1;
                        next_s.tick_cnt = 3'h0;
                    end
                end
            end
            ST_SETTLE: begin
                // Pads already follow the axis, so the panel settles here.
                if (s.standby_select) begin
                    next_s.state = ST_IDLE;
                end else if (s.wait_cnt <= 16'h0001) begin
                    next_s.state = ST_CONVERT;
                    next_s.conv_start = 1'b1;
                    next_s.tick_cnt = 3'h0;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 16'h0001;
                end
            end
            ST_CONVERT: begin
                if (s.standby_select) begin
                    // Aborted conversions write nothing; results stay put.
                    next_s.state = ST_IDLE;
                end else if (s.tick) begin
                    // The fifth tick samples the converter result.
                    if (s.tick_cnt == CONV_TICKS - 3'h1) begin
                        if (s.phase == PH_Y) begin
                            next_s.y_result_field = adc_data_i;
                        end else begin
                            next_s.x_result_field = adc_data_i;
                        end
                        next_s.conversion_end_flag = 1'b1;
                        if (s.auto_run && s.phase == PH_X) begin
                            next_s.phase = PH_Y;
                            next_s.state = ST_SETTLE;
                            next_s.wait_cnt = delay_load;
                        end else begin
                            next_s.done_irq = 1'b1;
                            next_s.auto_run = 1'b0;
                            next_s.state = ST_IDLE;
                        end
                    end else begin
                        next_s.tick_cnt = s.tick_cnt + 3'h1;
                    end
                end
            end
        endcase

        // Stylus wait: one touch pulse, then a gap of the delay value.
        // A stylus that stays down thus repeats the pulse at that interval.
        if (axis == AXIS_WAIT && !s.standby_select) begin
            if (s.touch_cnt != 16'h0000) begin
                next_s.touch_cnt = s.touch_cnt - 16'h0001;
            end else if (stylus_down_i) begin
                next_s.touch_irq = 1'b1;
                next_s.touch_cnt = delay_load;
            end
        end else begin
            next_s.touch_cnt = 16'h0000;
        end

        // Pad switches follow the touch bits unless an axis phase or the
        // stylus wait owns them.
        if (s.state != ST_IDLE && s.phase == PH_X) begin
            next_s.pads = PADS_X;
            next_s.channel_out = CHAN_Y_PLUS;
        end else if (s.state != ST_IDLE && s.phase == PH_Y) begin
            next_s.pads = PADS_Y;
            next_s.channel_out = CHAN_X_PLUS;
        end else if (s.state == ST_IDLE && axis == AXIS_WAIT) begin
            next_s.pads = PADS_WAIT;
            next_s.channel_out = s.channel_select;
        end else begin
            next_s.pads = s.touch_pad_control[7:3];
            next_s.channel_out = s.channel_select;
        end

        // Bus reads: registered data, answered one cycle after the strobe.
        if (bus_req) begin
            next_s.ack = 1'b1;
        end
        if (bus_rd) begin
            // Unmapped addresses read zero but are still answered.
            unique case (wb_adr_i)
                OFF_CONTROL: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rdata[CTL_END_FLAG] = s.conversion_end_flag;
                    next_s.rdata[CTL_DIV_EN] = s.divider_enable;
                    next_s.rdata[CTL_DIV_HI:CTL_DIV_LO] = s.divider_value;
                    next_s.rdata[CTL_CHAN_HI:CTL_CHAN_LO] = s.channel_select;
                    next_s.rdata[CTL_STANDBY] = s.standby_select;
                    next_s.rdata[CTL_READ_START] = s.read_start;
                    next_s.rdata[CTL_START] = s.start_bit;
                end
                OFF_TOUCH: begin
                    next_s.rdata = {24'h00_0000, s.touch_pad_control};
                end
                OFF_DELAY: begin
                    next_s.rdata = {16'h0000, s.settle_delay};
                end
                OFF_RESULT0: begin
                    next_s.rdata = result_word(s.x_result_field,
                        s.touch_pad_control, stylus_down_i);
                end
                OFF_RESULT1: begin
                    next_s.rdata = result_word(s.y_result_field,
                        s.touch_pad_control, stylus_down_i);
                end
                default: begin
                    next_s.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Bus writes, byte lane by byte lane; result registers are read only.
        // A byte lane left unselected keeps its old contents.
        if (bus_wr) begin
            if (wb_adr_i == OFF_CONTROL) begin
                if (wb_sel_i[0]) begin
                    next_s.divider_value[1:0] = wb_dat_i[7:6];
                    next_s.channel_select =
                        wb_dat_i[CTL_CHAN_HI:CTL_CHAN_LO];
                    next_s.standby_select = wb_dat_i[CTL_STANDBY];
                    next_s.read_start = wb_dat_i[CTL_READ_START];
                    if (wb_dat_i[CTL_START]) begin
                        next_s.start_bit = 1'b1;
                    end
                end
                if (wb_sel_i[1]) begin
                    next_s.divider_value[7:2] = wb_dat_i[13:8];
                    next_s.divider_enable = wb_dat_i[CTL_DIV_EN];
                end
            end
            if (wb_adr_i == OFF_TOUCH && wb_sel_i[0]) begin
                next_s.touch_pad_control = wb_dat_i[7:0];
            end
            if (wb_adr_i == OFF_DELAY) begin
                if (wb_sel_i[0]) begin
                    next_s.settle_delay[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    next_s.settle_delay[15:8] = wb_dat_i[15:8];
                end
            end
        end
    end

    // State register; a low clock enable freezes everything.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            s <= RESET_STATE;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // Every output comes straight from a field of the state register.
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign adc_start_o = s.conv_start;
    assign adc_clk_tick_o = s.tick;
    assign adc_channel_o = s.channel_out;
    assign adc_standby_o = s.standby_select;
    // Pad word order is y-minus, y-plus, x-minus, x-plus, pull-up.
    assign y_minus_ground_out_o = s.pads[4];
    assign y_plus_drive_out_n_o = s.pads[3];
    assign x_minus_ground_out_o = s.pads[2];
    assign x_plus_drive_out_n_o = s.pads[1];
    assign x_pullup_out_n_o = s.pads[0];
    assign conversion_done_irq_o = s.done_irq;
    assign stylus_touch_irq_o = s.touch_irq;

endmodule

// >>> verif/adc_touch_props.sv
// Checker of bus handshake, conversion and touch interrupt timing.
`timescale 1ns/1ps
module adc_touch_props (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic stylus_down_i,
    input wire logic adc_start_o,
    input wire logic adc_clk_tick_o,
    input wire logic adc_standby_o,
    input wire logic y_minus_ground_out_o,
    input wire logic x_pullup_out_n_o,
    input wire logic conversion_done_irq_o,
    input wire logic stylus_touch_irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [2:0] ticks;
    // Ticks since a start, its own cycle included; saturates at seven.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ticks <= 3'h0;
        end else if (adc_start_o && ce_i) begin
            ticks <= {2'h0, adc_clk_tick_o};
        end else if (adc_clk_tick_o && ce_i && ticks != 3'h7) begin
            ticks <= ticks + 3'h1;
        end
    end
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no bus answer");
    property p_ack_pulse;
        wb_ack_o && ce_i |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_start_pulse;
        adc_start_o && ce_i |=> !adc_start_o;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("long start");
    property p_done_ticks;
        conversion_done_irq_o |-> ticks == 3'h5;
    endproperty
    a_done_ticks: assert property (p_done_ticks) else $error("tick count");
    property p_touch_cause;
        stylus_touch_irq_o |-> $past(stylus_down_i);
    endproperty
    a_touch_cause: assert property (p_touch_cause) else $error("no stylus");
    property p_touch_gap;
        stylus_touch_irq_o && ce_i |=> !stylus_touch_irq_o;
    endproperty
    a_touch_gap: assert property (p_touch_gap) else $error("touch gap");
    property p_touch_mode;
        stylus_touch_irq_o |-> $past(!x_pullup_out_n_o && y_minus_ground_out_o);
    endproperty
    a_touch_mode: assert property (p_touch_mode) else $error("touch pads");
    property p_standby_idle;
        adc_standby_o && $past(adc_standby_o)
            |-> !adc_start_o && !conversion_done_irq_o;
    endproperty
    a_standby_idle: assert property (p_standby_idle) else $error("standby");
    property p_ce_freeze;
        !ce_i |=> $stable({wb_ack_o, adc_start_o, adc_standby_o,
            y_minus_ground_out_o, x_pullup_out_n_o});
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("not frozen");
    c_done: cover property (conversion_done_irq_o);
    c_touch: cover property (stylus_touch_irq_o);
    c_start: cover property (adc_start_o);
endmodule

bind adc_touch_screen_control adc_touch_props u_adc_touch_props (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .stylus_down_i(stylus_down_i), .adc_start_o(adc_start_o),
    .adc_clk_tick_o(adc_clk_tick_o), .adc_standby_o(adc_standby_o),
    .y_minus_ground_out_o(y_minus_ground_out_o),
    .x_pullup_out_n_o(x_pullup_out_n_o),
    .conversion_done_irq_o(conversion_done_irq_o),
    .stylus_touch_irq_o(stylus_touch_irq_o)
);

// >>> verif/adc_panel_model.sv
// Behavioural converter core and touch panel behind the pad switches.
`timescale 1ns/1ps
module adc_panel_model (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [2:0] channel_i,
    input wire logic pullup_n_i,
    input wire logic y_ground_i,
    input wire logic [9:0] sample_i,
    input wire logic touch_i,
    output logic [9:0] data_o,
    output logic stylus_o
);
    logic busy;
    logic [2:0] cnt;
    logic [9:0] held;
    logic [9:0] noise;
    // Hold the sample for five ticks; outside that the line wanders.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            busy <= 1'b0;
            cnt <= 3'h0;
            noise <= 10'h2A5;
        end else begin
            noise <= noise + 10'h0D5;
            if (start_i) begin
                busy <= 1'b1;
                cnt <= 3'h0;
                held <= (channel_i == 3'h7) ? ~sample_i : sample_i;
            end else if (busy && cnt == 3'h5) begin
                busy <= 1'b0;
            end else if (busy && tick_i) begin
                cnt <= cnt + 3'h1;
            end
        end
    end
    // Channel 7 reads the inverted sample so two axes differ.
    assign data_o = busy ? held : noise;
    // Contact is sensed only with the pull-up on and Y-minus grounded.
    assign stylus_o = touch_i && !pullup_n_i && y_ground_i;
endmodule

// >>> verif/adc_touch_screen_control_tb.sv
// Self-checking bench for the converter and touch-panel control.
`timescale 1ns/1ps
module adc_touch_screen_control_tb;
    import adc_touch_pkg::*;
    logic clk, rstn, ce, cyc, stb, we, tch, ack, st, tk, sb, stl;
    logic ym, ypn, xm, xpn, pun, dn, ti;
    logic [31:0] adr, wdat, rdat;
    logic [3:0] sel;
    logic [9:0] smp, adc_d, s;
    logic [2:0] chn, chn_st;
    logic [4:0] pads_st;
    logic [15:0] ctl;
    logic [31:0] exp_q[$];
    int error_cnt, checks_done, starts, dones, touches, n_div, t0;

    // Core clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    adc_panel_model u_adc_panel_model (.core_clk_i(clk), .resetn_i(rstn),
        .start_i(st), .tick_i(tk), .channel_i(chn), .pullup_n_i(pun),
        .y_ground_i(ym), .sample_i(smp), .touch_i(tch), .data_o(adc_d),
        .stylus_o(stl));
    adc_touch_screen_control u_adc_touch_screen_control (.core_clk_i(clk),
        .resetn_i(rstn), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .adc_data_i(adc_d),
        .stylus_down_i(stl), .adc_start_o(st), .adc_clk_tick_o(tk),
        .adc_channel_o(chn), .adc_standby_o(sb),
        .y_minus_ground_out_o(ym), .y_plus_drive_out_n_o(ypn),
        .x_minus_ground_out_o(xm), .x_plus_drive_out_n_o(xpn),
        .x_pullup_out_n_o(pun), .conversion_done_irq_o(dn),
        .stylus_touch_irq_o(ti));

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One classic cycle; a read leaves its expected word for the monitor.
    task automatic bus(input logic w, input logic [31:0] a, d, e);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        if (!w) exp_q.push_back(e);
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
    endtask

    task automatic wait_cnt(ref int c, input int c0, input int lim);
        int n;
        n = 0;
        while (c == c0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (c == c0) begin
            check("awaited event", 0, 1);
            complete_run();
        end
    endtask

    // Monitor: compares read answers and counts output pulses.
    always @(posedge clk) begin
        if (ack === 1'b1 && !we) check("read data", rdat,
            exp_q.size() ? exp_q.pop_front() : 32'hFFFF_FFFF);
        if (st === 1'b1) begin
            starts++;
            chn_st = chn;
            pads_st = {ym, ypn, xm, xpn, pun};
        end
        if (dn === 1'b1) dones++;
        if (ti === 1'b1) touches++;
    end

    // Mode m is the touch low bits: 0 normal, 1 X, 2 Y, 4 auto.
    task automatic convert(input logic [2:0] c, input logic [2:0] m);
        int s0, d0;
        logic [9:0] x;
        s = 10'($urandom);
        smp <= s;
        x = (c == 3'h7 && m == 3'h0) ? ~s : s;
        s0 = starts;
        d0 = dones;
        ctl = 16'h4001 | 16'(n_div << 6) | {10'h0, c, 3'h0};
        bus(1, OFF_TOUCH, {29'h0, m}, 0);
        bus(1, OFF_CONTROL, {16'h0, ctl}, 0);
        if (m == 3'h0) bus(0, OFF_CONTROL, 0, {16'h0, ctl & 16'h7FFE});
        wait_cnt(dones, d0, 400);
        repeat (40) @(posedge clk);
        check("done count", dones - d0, 1);
        check("start count", starts - s0, m[2] ? 2 : 1);
        check("channel", chn_st, m == 0 ? c : (m == 1 ? 5 : 7));
        if (m != 0) check("pads", pads_st, m == 1 ? 5'h0D : 5'h13);
        bus(1, OFF_TOUCH, 0, 0);
        bus(0, OFF_CONTROL, 0, {16'h0, (ctl | 16'h8000) & 16'hFFFE});
        if (m != 3'h2) bus(0, OFF_RESULT0, 0, {16'h0, 6'h20, x});
        if (m[1] | m[2]) bus(0, OFF_RESULT1, 0, {16'h0, 6'h20, ~s});
    endtask

    // Main sequence.
    initial begin
        {rstn, ce, cyc, stb, we, tch} = 6'b010000;
        {adr, wdat, sel, smp} = '0;
        sel = 4'h3;
        {error_cnt, checks_done, starts, dones, touches} = '0;
        void'($urandom(20467));
        n_div = 5 + $urandom % 3;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check("reset pads", {ym, ypn, xm, xpn, pun}, 5'h0B);
        bus(0, OFF_CONTROL, 0, 32'h3FC4);
        bus(0, OFF_TOUCH, 0, 32'h58);
        bus(0, 32'h5800_0040, 0, 0);
        bus(1, OFF_RESULT0, 32'h3FF, 0);
        bus(0, OFF_RESULT0, 0, 32'h8000);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        // Touch bits drive the pad outputs; bit 8 always reads zero.
        repeat (4) begin
            s = 10'($urandom) & 10'h0F8;
            bus(1, OFF_TOUCH, {23'h0, 1'b1, s[7:0]}, 0);
            bus(0, OFF_TOUCH, 0, {24'h0, s[7:0]});
            check("pad bits", {ym, ypn, xm, xpn, pun}, s[7:3]);
        end
        bus(1, OFF_DELAY, 3, 0);
        for (int ch = 0; ch < 8; ch++) convert(3'(ch), 3'h0);
        for (int i = 0; i < 3; i++) convert(3'h0, 3'(1 << i));
        // Stylus wait: sensing pads, then a touch interrupt on contact.
        bus(1, OFF_TOUCH, 32'h3, 0);
        repeat (3) @(posedge clk);
        check("wait pads", {ym, ypn, xm, xpn, pun}, 5'h1A);
        tch <= 1'b1;
        wait_cnt(touches, touches, 50);
        tch <= 1'b0;
        bus(1, OFF_TOUCH, 0, 0);
        // Standby holds results; start bit is void under start-by-read.
        t0 = starts;
        bus(1, OFF_CONTROL, 32'h4005 | 32'(n_div << 6), 0);
        repeat (60) @(posedge clk);
        check("standby", {sb, 8'(starts - t0)}, 9'h100);
        bus(0, OFF_RESULT1, 0, {16'h0, 6'h20, ~s});
        bus(1, OFF_CONTROL, 32'h4003 | 32'(n_div << 6), 0);
        repeat (60) @(posedge clk);
        check("start ignored", starts - t0, 0);
        t0 = dones;
        bus(0, OFF_RESULT0, 0, {16'h0, 6'h20, s});
        wait_cnt(dones, t0, 400);
        // A stopped prescaler stalls the conversion; standby then aborts.
        t0 = dones;
        bus(1, OFF_CONTROL, 32'h0001 | 32'(n_div << 6), 0);
        repeat (80) @(posedge clk);
        check("stalled", dones - t0, 0);
        bus(1, OFF_CONTROL, 32'h4, 0);
        repeat (5) @(posedge clk);
        complete_run();
    end
endmodule
